/* logic/rcpl_defs.svh */
// register offsets, field positions and reset values for the rail control pin logic
// assumes an APB slave with 32-bit data, one aligned word per register
`ifndef RCPL_DEFS_SVH
`define RCPL_DEFS_SVH

`define RCPL_NUM_REG        8
`define RCPL_NUM_OUT        3
// register byte addresses
`define RCPL_ADDR_GRP_EN2   12'h000
`define RCPL_ADDR_GRP_EN3   12'h004
`define RCPL_ADDR_GRP_EN4   12'h008
`define RCPL_ADDR_GRP_EN5   12'h00C
`define RCPL_ADDR_SLP_CFG   12'h010
`define RCPL_ADDR_OUT_CFG   12'h014
`define RCPL_ADDR_OUT_PG    12'h018
`define RCPL_ADDR_STATUS    12'h01C
`define RCPL_ADDR_IRQ       12'h020
// sleep configuration fields
`define RCPL_SLP_MODE_BIT   8
// output configuration fields: per output i, three bits at 4*i
`define RCPL_OC_SRC_PG      0
`define RCPL_OC_PUSHPULL    1
`define RCPL_OC_USER_BIT    2
// power good selection: byte i selects regulators for output i
`define RCPL_PG_FIELD_W     8
// reset values
`define RCPL_GRP_RST        8'h00
`define RCPL_OUT_CFG_RST    12'h000
`define RCPL_PG_SEL_RST     24'h000000
`define RCPL_IRQ_RST        8'h00

`endif

/* logic/rcpl_pkg.sv */
// types shared by the rail control pin logic
// constants live in rcpl_defs.svh
package rcpl_pkg;

    // sleep pin decode state, gray coded
    typedef enum logic [1:0]
    {
        RCPL_NORMAL = 2'b00,
        RCPL_ENTER  = 2'b01,
        RCPL_SLEEP  = 2'b11,
        RCPL_EXIT   = 2'b10
    } rcpl_slp_t;

endpackage

/* logic/rcpl_top.sv */
// rail control pin logic: control pin decode, general outputs, interrupt pin
// assumes control pins arrive asynchronously and power good from the regulators
//
// What this block does
// - outputs two and three select open-drain or push-pull drive by configuration
// - each output sources either combined power good of chosen regulators or a user bit
// - output four is always open-drain, with the same source choice
// - each control input enables its regulator group high, disables it low; input three enables only in enable mode
// - input three in sleep mode: low sleeps its group, high returns to normal
// - open-drain interrupt output signals pending bits of the interrupt status register
//
// Local design decisions: register access over APB and the address map.
`timescale 1ns/10ps
`include "rcpl_defs.svh"

module rcpl_top
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        rail_enable_in_two,
    input  wire logic        rail_enable_or_sleep_in_three,
    input  wire logic        rail_enable_in_four,
    input  wire logic        rail_enable_in_five,
    input  wire logic [7:0]  regulator_power_good,
    input  wire logic [7:0]  irq_event,
    output logic      [7:0]  regulator_enable,
    output logic      [7:0]  regulator_sleep,
    output logic             general_output_two_o,
    output logic             general_output_two_oe,
    output logic             general_output_three_o,
    output logic             general_output_three_oe,
    output logic             general_output_four_o,
    output logic             general_output_four_oe,
    output logic             interrupt_out_n_o,
    output logic             interrupt_out_n_oe
);

    typedef struct packed
    {
        logic [3:0]         sync1;
        logic [3:0]         sync2;
        logic [3:0][7:0]    grp;
        logic [7:0]         slp_grp;
        logic               slp_mode;
        logic [11:0]        out_cfg;
        logic [23:0]        pg_sel;
        logic [7:0]         irq;
        rcpl_pkg::rcpl_slp_t slp;
        logic [7:0]         en;
        logic [7:0]         sl;
        logic [2:0]         gpo;
        logic [31:0]        rdata;
    } rcpl_state_t;

    rcpl_state_t st;
    rcpl_state_t next_st;

    logic        wr;
    logic        rd;
    logic        mapped;
    logic [3:0]  pins;
    logic [2:0]  pg_ok;
    logic        slp_pin;

    assign pins = {rail_enable_in_five, rail_enable_in_four,
                   rail_enable_or_sleep_in_three, rail_enable_in_two};
    assign wr = psel && penable && pwrite;
    assign rd = psel && !penable && !pwrite;
    assign slp_pin = st.sync2[1];

    // address decode; unmapped addresses answer with pslverr
    always_comb
    begin
        case (paddr)
            `RCPL_ADDR_GRP_EN2, `RCPL_ADDR_GRP_EN3, `RCPL_ADDR_GRP_EN4,
            `RCPL_ADDR_GRP_EN5, `RCPL_ADDR_SLP_CFG, `RCPL_ADDR_OUT_CFG,
            `RCPL_ADDR_OUT_PG, `RCPL_ADDR_STATUS, `RCPL_ADDR_IRQ: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    // per-output power good: all chosen regulators good; empty selection reads good
    genvar gi;
    generate
        for (gi = 0; gi < `RCPL_NUM_OUT; gi++)
        begin : g_pg
            assign pg_ok[gi] = &(regulator_power_good
                                 | ~st.pg_sel[gi*`RCPL_PG_FIELD_W +: `RCPL_PG_FIELD_W]);
        end
    endgenerate

    always_comb
    begin
        next_st = st;
        // two-flop synchroniser; only sync2 is looked at
        next_st.sync1 = pins;
        next_st.sync2 = st.sync1;
        // sleep pin state; pin low means sleep
        case (st.slp)
            rcpl_pkg::RCPL_NORMAL: if (st.slp_mode && !slp_pin) next_st.slp = rcpl_pkg::RCPL_ENTER;
            rcpl_pkg::RCPL_ENTER:  next_st.slp = rcpl_pkg::RCPL_SLEEP;
            rcpl_pkg::RCPL_SLEEP:  if (!st.slp_mode || slp_pin) next_st.slp = rcpl_pkg::RCPL_EXIT;
            rcpl_pkg::RCPL_EXIT:   next_st.slp = rcpl_pkg::RCPL_NORMAL;
            default:               next_st.slp = rcpl_pkg::RCPL_NORMAL;
        endcase
        // enables: a group follows its pin; input three gives enables only in enable mode
        next_st.en = (st.sync2[0] ? st.grp[0] : 8'h00)
                   | ((st.sync2[1] && !st.slp_mode) ? st.grp[1] : 8'h00)
                   | (st.sync2[2] ? st.grp[2] : 8'h00)
                   | (st.sync2[3] ? st.grp[3] : 8'h00);
        next_st.sl = (st.slp == rcpl_pkg::RCPL_SLEEP) ? st.slp_grp : 8'h00;
        // output levels; user bit or combined power good
        for (int i = 0; i < `RCPL_NUM_OUT; i++)
        begin
            next_st.gpo[i] = st.out_cfg[4*i + `RCPL_OC_SRC_PG] ? pg_ok[i]
                           : st.out_cfg[4*i + `RCPL_OC_USER_BIT];
        end
        // interrupt status: set beats a write-one clear in the same cycle
        next_st.irq = st.irq | irq_event;
        if (wr && paddr == `RCPL_ADDR_IRQ)
            next_st.irq = (st.irq & ~pwdata[7:0]) | irq_event;
        // register writes in the access phase
        if (wr)
        begin
            case (paddr)
                `RCPL_ADDR_GRP_EN2: next_st.grp[0] = pwdata[7:0];
                `RCPL_ADDR_GRP_EN3: next_st.grp[1] = pwdata[7:0];
                `RCPL_ADDR_GRP_EN4: next_st.grp[2] = pwdata[7:0];
                `RCPL_ADDR_GRP_EN5: next_st.grp[3] = pwdata[7:0];
                `RCPL_ADDR_SLP_CFG:
                begin
                    next_st.slp_grp  = pwdata[7:0];
                    next_st.slp_mode = pwdata[`RCPL_SLP_MODE_BIT];
                end
                `RCPL_ADDR_OUT_CFG: next_st.out_cfg = pwdata[11:0];
                `RCPL_ADDR_OUT_PG:  next_st.pg_sel = pwdata[23:0];
                default: ;
            endcase
        end
        // read data captured in setup, presented in access
        if (rd)
        begin
            case (paddr)
                `RCPL_ADDR_GRP_EN2: next_st.rdata = {24'h000000, st.grp[0]};
                `RCPL_ADDR_GRP_EN3: next_st.rdata = {24'h000000, st.grp[1]};
                `RCPL_ADDR_GRP_EN4: next_st.rdata = {24'h000000, st.grp[2]};
                `RCPL_ADDR_GRP_EN5: next_st.rdata = {24'h000000, st.grp[3]};
                `RCPL_ADDR_SLP_CFG: next_st.rdata = {23'h000000, st.slp_mode, st.slp_grp};
                `RCPL_ADDR_OUT_CFG: next_st.rdata = {20'h00000, st.out_cfg};
                `RCPL_ADDR_OUT_PG:  next_st.rdata = {8'h00, st.pg_sel};
                `RCPL_ADDR_STATUS:  next_st.rdata = {9'h000, st.gpo, st.sync2, st.sl, st.en};
                `RCPL_ADDR_IRQ:     next_st.rdata = {24'h000000, st.irq};
                default:            next_st.rdata = 32'h00000000;
            endcase
        end
    end

    // one register for all state
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    // zero-wait APB slave
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign prdata  = st.rdata;

    assign regulator_enable = st.en;
    assign regulator_sleep  = st.sl;

    // open drain drives only low; push-pull drives always
    assign general_output_two_o    = st.gpo[0];
    assign general_output_two_oe   = st.out_cfg[`RCPL_OC_PUSHPULL] || !st.gpo[0];
    assign general_output_three_o  = st.gpo[1];
    assign general_output_three_oe = st.out_cfg[4 + `RCPL_OC_PUSHPULL] || !st.gpo[1];
    // output four ignores the push-pull bit
    assign general_output_four_o   = 1'b0;
    assign general_output_four_oe  = !st.gpo[2];
    assign interrupt_out_n_o       = 1'b0;
    assign interrupt_out_n_oe      = |st.irq;

    a_en_follow_pin: assert property (@(posedge pclk) disable iff (!presetn)
        st.sync2[0] && !$past(st.sync2[0]) |=> (regulator_enable & st.grp[0]) == st.grp[0])
        else $error("group two not enabled after pin high");
    a_sync_two_flop: assert property (@(posedge pclk) disable iff (!presetn)
        ##2 st.sync2 == $past(pins, 2)) else $error("synchroniser delay wrong");
    sequence s_pin_low;
        st.slp_mode && !slp_pin && st.slp == rcpl_pkg::RCPL_NORMAL;
    endsequence
    a_sleep_enter: assert property (@(posedge pclk) disable iff (!presetn)
        s_pin_low ##1 st.slp_mode [*2] |-> st.slp == rcpl_pkg::RCPL_SLEEP)
        else $error("sleep not entered");
    // a set push-pull bit on output four must still leave a high level undriven
    a_four_open: assert property (@(posedge pclk) disable iff (!presetn)
        st.out_cfg[8 + `RCPL_OC_PUSHPULL] && st.gpo[2] |-> !general_output_four_oe)
        else $error("output four drives high");
    a_two_open: assert property (@(posedge pclk) disable iff (!presetn)
        !st.out_cfg[`RCPL_OC_PUSHPULL] && general_output_two_oe |-> !general_output_two_o)
        else $error("output two drives high in open drain");
    a_user_src: assert property (@(posedge pclk) disable iff (!presetn)
        !st.out_cfg[`RCPL_OC_SRC_PG] && $stable(st.out_cfg) |=> st.gpo[0] == $past(st.out_cfg[2]))
        else $error("user bit not on output two");
    a_irq_pin: assert property (@(posedge pclk) disable iff (!presetn)
        |irq_event |=> !interrupt_out_n_oe == 1'b0) else $error("interrupt pin not asserted");
    a_irq_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
        irq_event[0] |=> st.irq[0]) else $error("interrupt event lost");

endmodule

/* sim/rcpl_host_model.sv */
// host side model: drives the control pins and power good, pulls the output lines up
// assumes the bench changes requests by non-blocking assignment after a rising edge
`timescale 1ns/10ps
module rcpl_host_model
(
    input  wire logic [3:0] pin_req,
    input  wire logic [7:0] pg_req,
    input  wire logic [3:0] line_o,
    input  wire logic [3:0] line_oe,
    output logic      [3:0] pins,
    output logic      [7:0] power_good,
    output logic      [3:0] line
);
    // pins follow the request asynchronously, as a real controller would
    assign pins = pin_req;
    assign power_good = pg_req;
    // pull-up on every line: a released line reads high, never a stale level
    assign line = line_o | ~line_oe;
endmodule

/* sim/rcpl_top_test.sv */
// bench for the rail control pin logic: apb tasks plus pin and line checks
// assumes zero-wait apb slave and the host model on the pins
`timescale 1ns/10ps
module rcpl_top_test;
    logic        pclk = 0;
    logic        presetn = 0;
    logic        psel = 0;
    logic        penable = 0;
    logic        pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic        pready;
    logic        pslverr;
    logic        er;
    logic [3:0]  pin_req = 0;
    logic [7:0]  pg_req = 0;
    logic [7:0]  irq_event = 0;
    logic [3:0]  pins;
    logic [7:0]  pg;
    logic [3:0]  lo;
    logic [3:0]  loe;
    logic [3:0]  line;
    logic [7:0]  ren;
    logic [7:0]  rsl;
    int          miscompares = 0;
    int          n_checks = 0;
    int          i;
    always #25 pclk = ~pclk;
    rcpl_top rcpl_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rail_enable_in_two(pins[0]), .rail_enable_or_sleep_in_three(pins[1]),
        .rail_enable_in_four(pins[2]), .rail_enable_in_five(pins[3]),
        .regulator_power_good(pg), .irq_event(irq_event), .regulator_enable(ren),
        .regulator_sleep(rsl), .general_output_two_o(lo[0]), .general_output_two_oe(loe[0]),
        .general_output_three_o(lo[1]), .general_output_three_oe(loe[1]),
        .general_output_four_o(lo[2]), .general_output_four_oe(loe[2]),
        .interrupt_out_n_o(lo[3]), .interrupt_out_n_oe(loe[3]));
    rcpl_host_model rcpl_host_model_i (.pin_req(pin_req), .pg_req(pg_req), .line_o(lo),
        .line_oe(loe), .pins(pins), .power_good(pg), .line(line));
    task test_done();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e)
        begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    // request held until pready is seen high at a rising edge
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        for (k = 0; k < 20; k++)
        begin
            @(posedge pclk);
            if (pready === 1'b1)
                break;
        end
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
        if (k == 20)
        begin
            miscompares++;
            test_done();
        end
    endtask
    // pins pass a synchroniser, so wait a bounded time for the outputs
    task wait_out(input logic [3:0] p, input logic [7:0] en, input logic [7:0] sl);
        int k;
        @(posedge pclk);
        pin_req <= p;
        for (k = 0; k < 10 && !(ren === en && rsl === sl); k++)
            @(negedge pclk);
        chk("enable", 32'(en), 32'(ren));
        chk("sleep", 32'(sl), 32'(rsl));
        // a wait that ran out has already counted its mismatch in chk
        if (ren !== en || rsl !== sl)
            test_done();
    endtask
    task lines(input logic [3:0] oe, input logic [3:0] lv);
        repeat (3) @(negedge pclk);
        chk("line_oe", 32'(oe), 32'(loe));
        chk("line", 32'(lv), 32'(line));
    endtask
    initial
    begin
        repeat (6) @(posedge pclk);
        presetn <= 1;
        for (i = 0; i < 9; i++)
        begin
            xfer(0, 12'(i * 4), 32'h0);
            chk("reset_reg", 32'h0, rd);
        end
        lines(4'h7, 4'h8);
        $display("test reset done");
        for (i = 0; i < 4; i++)
            xfer(1, 12'(i * 4), 32'(1 << i));
        for (i = 0; i < 4; i++)
            wait_out(4'(1 << i), 8'(1 << i), 8'h00);
        wait_out(4'hF, 8'h0F, 8'h00);
        wait_out(4'h0, 8'h00, 8'h00);
        $display("test enable done");
        xfer(1, 12'h010, 32'h130);
        wait_out(4'h6, 8'h04, 8'h00);
        wait_out(4'h4, 8'h04, 8'h30);
        wait_out(4'h6, 8'h04, 8'h00);
        $display("test sleep done");
        xfer(1, 12'h018, 32'h300);
        xfer(1, 12'h014, 32'h616);
        pg_req <= 8'h01;
        lines(4'h3, 4'hD);
        @(posedge pclk);
        pg_req <= 8'h03;
        lines(4'h1, 4'hF);
        xfer(1, 12'h014, 32'h012);
        lines(4'h5, 4'hA);
        $display("test outputs done");
        @(posedge pclk);
        irq_event <= 8'h05;
        @(posedge pclk);
        irq_event <= 8'h00;
        xfer(1, 12'h020, 32'h1);
        xfer(0, 12'h020, 32'h0);
        chk("irq_status", 32'h4, rd);
        lines(4'hD, 4'h2);
        xfer(1, 12'h020, 32'h4);
        lines(4'h5, 4'hA);
        $display("test interrupt done");
        // output two on power good of regulator 0, output three push-pull high
        xfer(1, 12'h018, 32'h1);
        xfer(1, 12'h014, 32'h61);
        lines(4'h6, 4'hB);
        @(posedge pclk);
        pg_req <= 8'h02;
        lines(4'h7, 4'hA);
        $display("test push-pull done");
        xfer(1, 12'h040, 32'hFFFF);
        chk("slverr", 32'h1, 32'(er));
        xfer(0, 12'h040, 32'h0);
        chk("unmapped", 32'h0, rd);
        $display("test unmapped done");
        test_done();
    end
endmodule
